// >>> mqe_pkg.sv
// Shared constants and carrier types for the queue event monitor
package mqe_pkg;

	localparam int ADDR_W  = 32;
	localparam int DATA_W  = 64;
	localparam int BE_W    = 8;
	localparam int DEPTH   = 8;
	localparam int IDX_W   = 3;
	localparam int CNT_W   = 4;
	localparam int NUM_CTR = 4;
	localparam int INC_W   = 6;
	localparam int CTL_W   = 16;
	localparam int NBANK   = 8;

	// Counter control word: event code low, unit mask in bits 15:8
	localparam int CODE_LSB  = 0;
	localparam int UMASK_LSB = 8;

	// Rank and bank positions inside a request address
	localparam int BANK_LSB = 0;
	localparam int RANK_LSB = 3;
	localparam int SEL_W    = 3;

	localparam logic [SEL_W-1:0] RANK_ZERO  = 3'h0;
	localparam logic [SEL_W-1:0] RANK_ONE   = 3'h1;
	localparam logic [SEL_W-1:0] RANK_TWO   = 3'h2;
	localparam logic [SEL_W-1:0] RANK_SEVEN = 3'h7;

	localparam logic [CNT_W-1:0] QUEUE_DEPTH = 4'h8;
	localparam logic [BE_W-1:0]  BE_NONE     = 8'h00;
	localparam logic [INC_W-1:0] OCC_MAX     = 6'h20;
	localparam logic [INC_W-1:0] INC_RESET   = 6'h00;

	// Event codes
	localparam logic [7:0] EV_READ_QUEUE_ALLOCATIONS      = 8'h10;
	localparam logic [7:0] EV_READ_QUEUE_NONEMPTY_CYCLES  = 8'h11;
	localparam logic [7:0] EV_WRITE_QUEUE_ALLOCATIONS     = 8'h20;
	localparam logic [7:0] EV_WRITE_QUEUE_NONEMPTY_CYCLES = 8'h21;
	localparam logic [7:0] EV_WRITE_QUEUE_FULL_CYCLES     = 8'h22;
	localparam logic [7:0] EV_WRITE_QUEUE_READ_MATCH      = 8'h23;
	localparam logic [7:0] EV_WRITE_QUEUE_WRITE_MATCH     = 8'h24;
	localparam logic [7:0] EV_BUFFERED_WRITE_PUSH         = 8'h90;
	localparam logic [7:0] EV_BUFFERED_WRITE_OCCUPANCY    = 8'h91;
	localparam logic [7:0] EV_READ_COLUMN_RANK_SEVEN      = 8'hb7;
	localparam logic [7:0] EV_WRITE_COLUMN_RANK_ZERO      = 8'hb8;
	localparam logic [7:0] EV_WRITE_COLUMN_RANK_ONE       = 8'hb9;
	localparam logic [7:0] EV_WRITE_COLUMN_RANK_TWO       = 8'hba;
	localparam logic [7:0] EV_WRITE_TO_READ_MODE_SWITCH   = 8'hc0;
	localparam logic [7:0] EV_MODE_REQUEST_DENIED         = 8'hc1;

	typedef struct packed {
		logic              time_critical_class;
		logic [ADDR_W-1:0] addr;
	} mqe_rd_req_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [BE_W-1:0]   be;
	} mqe_wr_req_t;

	typedef struct packed {
		logic              is_write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [BE_W-1:0]   be;
	} mqe_cmd_t;

	// Per-cycle event sources; push is {read_major_mode, write_major_mode},
	// mode_switch is {buffered_retry, starvation, low_threshold}
	typedef struct packed {
		logic             rpq_ne;
		logic             rpq_ins;
		logic             wpq_full;
		logic             wpq_ne;
		logic             wpq_ins;
		logic             rd_match;
		logic             wr_match;
		logic [NBANK-1:0] rd_col_r7;
		logic [NBANK-1:0] wr_col_r0;
		logic [NBANK-1:0] wr_col_r1;
		logic [NBANK-1:0] wr_col_r2;
		logic [1:0]       push;
		logic [INC_W-1:0] occupancy;
		logic [2:0]       mode_switch;
		logic             mode_denied;
	} mqe_evt_t;

endpackage

// >>> mqe_evsel.sv
// One counter's event selector: code and unit mask to an increment
`timescale 1ns/100ps
`default_nettype none
module mqe_evsel
	import mqe_pkg::*;
(
	input  wire logic             mclk_i,
	input  wire logic             rst_n_i,
	input  wire logic [CTL_W-1:0] ctl_i,
	input  wire mqe_evt_t         evt_i,
	output logic      [INC_W-1:0] inc_o
);

	logic [INC_W-1:0] inc_ff;
	logic [INC_W-1:0] nxt_inc;

	// One count per sub-event matching any set unit-mask bit
	function automatic logic [INC_W-1:0] hits(input logic [7:0] v);
		logic [INC_W-1:0] s;
		s = INC_RESET;
		for (int i = 0; i < 8; i++) begin
			s = s + {{(INC_W-1){1'b0}}, v[i]}; // [RQ23]
		end
		return s;
	endfunction

	always_comb begin
		logic [7:0] code;
		logic [7:0] um;
		code = ctl_i[CODE_LSB +: 8];
		um   = ctl_i[UMASK_LSB +: 8]; // [RQ22]
		case (code)
		EV_READ_QUEUE_NONEMPTY_CYCLES:  nxt_inc = hits({7'h0, evt_i.rpq_ne}); // [RQ1]
		EV_READ_QUEUE_ALLOCATIONS:      nxt_inc = hits({7'h0, evt_i.rpq_ins}); // [RQ2]
		EV_WRITE_QUEUE_FULL_CYCLES:     nxt_inc = hits({7'h0, evt_i.wpq_full}); // [RQ5]
		EV_WRITE_QUEUE_NONEMPTY_CYCLES: nxt_inc = hits({7'h0, evt_i.wpq_ne}); // [RQ6]
		EV_WRITE_QUEUE_ALLOCATIONS:     nxt_inc = hits({7'h0, evt_i.wpq_ins}); // [RQ7]
		EV_WRITE_QUEUE_READ_MATCH:      nxt_inc = hits({7'h0, evt_i.rd_match}); // [RQ14]
		EV_WRITE_QUEUE_WRITE_MATCH:     nxt_inc = hits({7'h0, evt_i.wr_match}); // [RQ14]
		EV_READ_COLUMN_RANK_SEVEN:      nxt_inc = hits(um & evt_i.rd_col_r7); // [RQ15]
		EV_WRITE_COLUMN_RANK_ZERO:      nxt_inc = hits(um & evt_i.wr_col_r0); // [RQ16]
		EV_WRITE_COLUMN_RANK_ONE:       nxt_inc = hits(um & evt_i.wr_col_r1); // [RQ16]
		EV_WRITE_COLUMN_RANK_TWO:       nxt_inc = hits(um & evt_i.wr_col_r2); // [RQ16]
		EV_BUFFERED_WRITE_PUSH:         nxt_inc = hits(um & {6'h0, evt_i.push}); // [RQ17]
		EV_BUFFERED_WRITE_OCCUPANCY:    nxt_inc = (evt_i.occupancy > OCC_MAX) ?
			OCC_MAX : evt_i.occupancy; // [RQ18]
		// One switch counts once, however many of its causes are enabled
		EV_WRITE_TO_READ_MODE_SWITCH:   nxt_inc = hits({7'h0,
			|(um & {5'h0, evt_i.mode_switch})}); // [RQ19] [RQ21]
		EV_MODE_REQUEST_DENIED:         nxt_inc = hits({7'h0, evt_i.mode_denied}); // [RQ20]
		default:                        nxt_inc = INC_RESET;
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			inc_ff <= INC_RESET;
		end else begin
			inc_ff <= nxt_inc;
		end
	end

	assign inc_o = inc_ff;

endmodule
`default_nettype wire

// >>> mqe_rpq.sv
// Read pending queue: in-order FIFO of accepted read requests
`timescale 1ns/100ps
`default_nettype none
module mqe_rpq
	import mqe_pkg::*;
(
	input  wire logic             mclk_i,
	input  wire logic             rst_n_i,
	input  wire logic             push_i,
	input  wire mqe_rd_req_t      data_i,
	input  wire logic             pop_i,
	output mqe_rd_req_t           head_o,
	output logic      [CNT_W-1:0] count_o,
	output logic                  empty_o
);

	mqe_rd_req_t      mem_ff [DEPTH];
	mqe_rd_req_t      nxt_mem [DEPTH];
	logic [IDX_W-1:0] wp_ff;
	logic [IDX_W-1:0] rp_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic [IDX_W-1:0] nxt_wp;
	logic [IDX_W-1:0] nxt_rp;
	logic [CNT_W-1:0] nxt_cnt;
	logic             do_pop;

	always_comb begin
		nxt_mem = mem_ff;
		nxt_wp  = wp_ff;
		nxt_rp  = rp_ff;
		nxt_cnt = cnt_ff;
		do_pop  = pop_i && (cnt_ff != '0);
		if (push_i) begin
			nxt_mem[wp_ff] = data_i;
			nxt_wp         = wp_ff + 3'h1;
		end
		if (do_pop) begin
			nxt_rp = rp_ff + 3'h1;
		end
		nxt_cnt = cnt_ff + {3'h0, push_i} - {3'h0, do_pop};
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mem_ff <= '{default: '0};
			wp_ff  <= '0;
			rp_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			mem_ff <= nxt_mem;
			wp_ff  <= nxt_wp;
			rp_ff  <= nxt_rp;
			cnt_ff <= nxt_cnt;
		end
	end

	assign head_o  = mem_ff[rp_ff];
	assign count_o = cnt_ff;
	assign empty_o = (cnt_ff == '0);

endmodule
`default_nettype wire

// >>> mqe_monitor.sv
// Memory controller channel queues with performance event generation
// Functional notes
// [RQ1] Event 0x11 adds one each cycle the read queue is not empty.
// [RQ2] Event 0x10 counts every read queue allocation, both request classes.
// [RQ3] Read entry allocates just after entry, frees when its column access issues.
// [RQ4] Home agent sends requests only while holding a free-entry credit.
// [RQ5] Event 0x22 counts write queue full cycles; no writes accepted then.
// [RQ6] Event 0x21 adds one each cycle the write queue is not empty.
// [RQ7] Event 0x20 counts every write queue allocation.
// [RQ8] Write entry stays until its write is issued to memory.
// [RQ9] Writes report completion once posted, not after the memory write.
// [RQ10] Reads and writes may pass pending writes only to different addresses.
// [RQ11] Every read and write first searches the write queue by address.
// [RQ12] A read matching a pending write takes data from the write queue.
// [RQ13] Matching full write overwrites; matching partial write merges its bytes only.
// [RQ14] Events 0x23 and 0x24 count read and write matches in write queue.
// [RQ15] Event 0xb7 counts rank 7 read column accesses, unit-mask bit per bank.
// [RQ16] Events 0xb8-0xba count rank 0-2 write column accesses per bank.
// [RQ17] Event 0x90 counts buffered pushes; bit0 write mode, bit1 read mode.
// [RQ18] Event 0x91 adds buffered write buffer occupancy, up to 32 a cycle.
// [RQ19] Event 0xc0 counts write-to-read mode switches by three selectable causes.
// [RQ20] Event 0xc1 counts denied major mode requests.
// [RQ21] Any event on any of counters 0-3; one per cycle except occupancy.
// [RQ22] Unit mask sits in bits 15:8 beside the event code.
// [RQ23] Several mask bits set: one count per matching sub-event; event 0xc0 counts a switch once however many causes match.
`timescale 1ns/100ps
`default_nettype none
module mqe_monitor
	import mqe_pkg::*;
(
	input  wire logic                   mclk_i,
	input  wire logic                   rst_n_i,
	input  wire logic                   rd_req_valid_i,
	input  wire mqe_rd_req_t            rd_req_i,
	input  wire logic                   wr_req_valid_i,
	input  wire mqe_wr_req_t            wr_req_i,
	input  wire logic                   mem_ready_i,
	input  wire logic                   write_major_mode_i,
	input  wire logic                   buffered_write_push_i,
	input  wire logic       [INC_W-1:0] buffered_write_occupancy_i,
	input  wire logic             [2:0] mode_switch_cause_i,
	input  wire logic                   mode_request_denied_i,
	input  wire logic [NUM_CTR-1:0][CTL_W-1:0] ctr_ctl_i,
	output logic                        rd_queue_full_o,
	output logic                        wr_queue_full_o,
	output logic                        wr_posted_o,
	output logic                        cmd_valid_o,
	output mqe_cmd_t                    cmd_o,
	output logic                        rd_fwd_valid_o,
	output mqe_wr_req_t                 rd_fwd_o,
	output logic [NUM_CTR-1:0][INC_W-1:0] ctr_inc_o
);

	// Request intake stage
	logic        rd_in_v_ff;
	mqe_rd_req_t rd_in_ff;
	logic        wr_in_v_ff;
	mqe_wr_req_t wr_in_ff;
	logic        nxt_rd_in_v;
	mqe_rd_req_t nxt_rd_in;
	logic        nxt_wr_in_v;
	mqe_wr_req_t nxt_wr_in;

	// Write pending queue storage
	logic [DEPTH-1:0]  wv_ff;
	logic [ADDR_W-1:0] wa_ff [DEPTH];
	logic [DATA_W-1:0] wd_ff [DEPTH];
	logic [BE_W-1:0]   wb_ff [DEPTH];
	logic [DEPTH-1:0]  nxt_wv;
	logic [ADDR_W-1:0] nxt_wa [DEPTH];
	logic [DATA_W-1:0] nxt_wd [DEPTH];
	logic [BE_W-1:0]   nxt_wb [DEPTH];

	// Outputs and flags
	logic        rd_full_ff;
	logic        wr_full_ff;
	logic        cmd_v_ff;
	mqe_cmd_t    cmd_ff;
	logic        fwd_v_ff;
	mqe_wr_req_t fwd_ff;
	mqe_evt_t    evt_ff;
	logic        nxt_rd_full;
	logic        nxt_wr_full;
	logic        nxt_cmd_v;
	mqe_cmd_t    nxt_cmd;
	logic        nxt_fwd_v;
	mqe_wr_req_t nxt_fwd;
	mqe_evt_t    nxt_evt;

	// Read queue wires
	mqe_rd_req_t      rpq_head;
	logic [CNT_W-1:0] rpq_count;
	logic             rpq_empty;
	logic             rpq_pop;

	// Scheduling terms
	logic [DEPTH-1:0]  rd_hit_vec;
	logic [DEPTH-1:0]  wr_hit_vec;
	logic [IDX_W-1:0]  rd_hit_idx;
	logic [IDX_W-1:0]  wr_hit_idx;
	logic [IDX_W-1:0]  issue_idx;
	logic [IDX_W-1:0]  free_idx;
	logic              issue_wr;
	logic              issue_rd;
	logic              fwd_rd;
	logic              wr_alloc;
	logic              wr_merge;
	logic [CNT_W-1:0]  wpq_count;
	logic [CNT_W-1:0]  nxt_wpq_count;

	mqe_rpq u_rpq (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.push_i  (rd_in_v_ff), // [RQ3]
		.data_i  (rd_in_ff),
		.pop_i   (rpq_pop),
		.head_o  (rpq_head),
		.count_o (rpq_count),
		.empty_o (rpq_empty)
	);

	// Intake: a request is refused while its queue reports full; the
	// home agent is expected to hold credits so this never drops work
	always_comb begin
		nxt_rd_in_v = rd_req_valid_i && !rd_full_ff; // [RQ4]
		nxt_rd_in   = rd_req_i;
		nxt_wr_in_v = wr_req_valid_i && !wr_full_ff; // [RQ5]
		nxt_wr_in   = wr_req_i;
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_in_v_ff <= 1'b0;
			rd_in_ff   <= '0;
			wr_in_v_ff <= 1'b0;
			wr_in_ff   <= '0;
		end else begin
			rd_in_v_ff <= nxt_rd_in_v;
			rd_in_ff   <= nxt_rd_in;
			wr_in_v_ff <= nxt_wr_in_v;
			wr_in_ff   <= nxt_wr_in;
		end
	end

	// Address search and issue selection over the write queue
	always_comb begin
		issue_idx  = '0;
		free_idx   = '0;
		rd_hit_idx = '0;
		wr_hit_idx = '0;
		wpq_count  = '0;
		for (int i = DEPTH - 1; i >= 0; i--) begin
			if (wv_ff[i]) begin
				issue_idx = IDX_W'(i);
			end else begin
				free_idx = IDX_W'(i);
			end
			wpq_count = wpq_count + {3'h0, wv_ff[i]};
		end
		// Write major mode favours draining writes; reads go otherwise
		issue_wr = mem_ready_i && (wv_ff != '0) &&
			(write_major_mode_i || rpq_empty);
		for (int i = 0; i < DEPTH; i++) begin
			rd_hit_vec[i] = wv_ff[i] && (wa_ff[i] == rpq_head.addr); // [RQ11]
			// An entry leaving this cycle takes no merge; a new one is made
			wr_hit_vec[i] = wv_ff[i] && (wa_ff[i] == wr_in_ff.addr) &&
				!(issue_wr && (issue_idx == IDX_W'(i))); // [RQ11]
		end
		for (int i = DEPTH - 1; i >= 0; i--) begin
			if (rd_hit_vec[i]) begin
				rd_hit_idx = IDX_W'(i);
			end
			if (wr_hit_vec[i]) begin
				wr_hit_idx = IDX_W'(i);
			end
		end
		fwd_rd   = !rpq_empty && (rd_hit_vec != '0); // [RQ12]
		// A read never passes a write to its own address
		issue_rd = !rpq_empty && !fwd_rd && mem_ready_i && !issue_wr; // [RQ10]
		rpq_pop  = fwd_rd || issue_rd; // [RQ3]
		wr_merge = wr_in_v_ff && (wr_hit_vec != '0);
		wr_alloc = wr_in_v_ff && (wr_hit_vec == '0); // [RQ7]
	end

	// Write queue update: merge, allocate and release
	always_comb begin
		nxt_wv = wv_ff;
		nxt_wa = wa_ff;
		nxt_wd = wd_ff;
		nxt_wb = wb_ff;
		if (issue_wr) begin
			nxt_wv[issue_idx] = 1'b0; // [RQ8]
		end
		if (wr_merge) begin
			for (int b = 0; b < BE_W; b++) begin
				if (wr_in_ff.be[b]) begin
					nxt_wd[wr_hit_idx][b*8 +: 8] = wr_in_ff.data[b*8 +: 8]; // [RQ13]
				end
			end
			nxt_wb[wr_hit_idx] = wb_ff[wr_hit_idx] | wr_in_ff.be; // [RQ13]
		end
		if (wr_alloc) begin
			// Partial data is kept with its byte mask; no fill read needed
			nxt_wv[free_idx] = 1'b1;
			nxt_wa[free_idx] = wr_in_ff.addr;
			nxt_wd[free_idx] = wr_in_ff.data;
			nxt_wb[free_idx] = wr_in_ff.be; // [RQ13]
		end
		nxt_wpq_count = wpq_count + {3'h0, wr_alloc} - {3'h0, issue_wr};
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wv_ff <= '0;
			wa_ff <= '{default: '0};
			wd_ff <= '{default: '0};
			wb_ff <= '{default: BE_NONE};
		end else begin
			wv_ff <= nxt_wv;
			wa_ff <= nxt_wa;
			wd_ff <= nxt_wd;
			wb_ff <= nxt_wb;
		end
	end

	// Full flags count the intake stage too, so a request already taken
	// always finds a slot
	always_comb begin
		nxt_wr_full = ({1'b0, nxt_wpq_count} + {4'h0, nxt_wr_in_v}) >=
			{1'b0, QUEUE_DEPTH}; // [RQ5]
		nxt_rd_full = ({1'b0, rpq_count} + {4'h0, rd_in_v_ff} +
			{4'h0, nxt_rd_in_v} - {4'h0, rpq_pop}) >= {1'b0, QUEUE_DEPTH};
	end

	// Memory command and forwarded read data
	always_comb begin
		nxt_cmd_v = issue_wr || issue_rd;
		nxt_cmd   = '0;
		if (issue_wr) begin
			nxt_cmd.is_write = 1'b1;
			nxt_cmd.addr     = wa_ff[issue_idx];
			nxt_cmd.data     = wd_ff[issue_idx];
			nxt_cmd.be       = wb_ff[issue_idx];
		end else if (issue_rd) begin
			nxt_cmd.addr = rpq_head.addr;
		end
		nxt_fwd_v = fwd_rd; // [RQ12]
		nxt_fwd   = '0;
		if (fwd_rd) begin
			nxt_fwd.addr = rpq_head.addr;
			nxt_fwd.data = wd_ff[rd_hit_idx];
			nxt_fwd.be   = wb_ff[rd_hit_idx];
		end
	end

	// Event sources sampled once a cycle for all four counters
	always_comb begin
		logic [SEL_W-1:0] rank;
		logic [NBANK-1:0] bank_hot;
		rank     = nxt_cmd.addr[RANK_LSB +: SEL_W];
		bank_hot = 8'h01 << nxt_cmd.addr[BANK_LSB +: SEL_W];
		nxt_evt          = '0;
		nxt_evt.rpq_ne   = !rpq_empty; // [RQ1]
		nxt_evt.rpq_ins  = rd_in_v_ff; // [RQ2]
		nxt_evt.wpq_full = wr_full_ff; // [RQ5]
		nxt_evt.wpq_ne   = (wv_ff != '0); // [RQ6]
		nxt_evt.wpq_ins  = wr_alloc; // [RQ7]
		nxt_evt.rd_match = fwd_rd; // [RQ14]
		nxt_evt.wr_match = wr_merge; // [RQ14]
		if (issue_rd && (rank == RANK_SEVEN)) begin
			nxt_evt.rd_col_r7 = bank_hot; // [RQ15]
		end
		if (issue_wr && (rank == RANK_ZERO)) begin
			nxt_evt.wr_col_r0 = bank_hot; // [RQ16]
		end
		if (issue_wr && (rank == RANK_ONE)) begin
			nxt_evt.wr_col_r1 = bank_hot; // [RQ16]
		end
		if (issue_wr && (rank == RANK_TWO)) begin
			nxt_evt.wr_col_r2 = bank_hot; // [RQ16]
		end
		nxt_evt.push = {buffered_write_push_i && !write_major_mode_i,
			buffered_write_push_i && write_major_mode_i}; // [RQ17]
		nxt_evt.occupancy   = buffered_write_occupancy_i; // [RQ18]
		nxt_evt.mode_switch = mode_switch_cause_i; // [RQ19]
		nxt_evt.mode_denied = mode_request_denied_i; // [RQ20]
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_full_ff <= 1'b0;
			wr_full_ff <= 1'b0;
			cmd_v_ff   <= 1'b0;
			cmd_ff     <= '0;
			fwd_v_ff   <= 1'b0;
			fwd_ff     <= '0;
			evt_ff     <= '0;
		end else begin
			rd_full_ff <= nxt_rd_full;
			wr_full_ff <= nxt_wr_full;
			cmd_v_ff   <= nxt_cmd_v;
			cmd_ff     <= nxt_cmd;
			fwd_v_ff   <= nxt_fwd_v;
			fwd_ff     <= nxt_fwd;
			evt_ff     <= nxt_evt;
		end
	end

	// Every counter sees the same event set
	for (genvar c = 0; c < NUM_CTR; c++) begin : g_ctr
		mqe_evsel u_evsel (
			.mclk_i  (mclk_i),
			.rst_n_i (rst_n_i),
			.ctl_i   (ctr_ctl_i[c]),
			.evt_i   (evt_ff),
			.inc_o   (ctr_inc_o[c]) // [RQ21]
		);
	end

	assign rd_queue_full_o = rd_full_ff;
	assign wr_queue_full_o = wr_full_ff;
	// Posted completion: one cycle after acceptance, before any DRAM write
	assign wr_posted_o     = wr_in_v_ff; // [RQ9]
	assign cmd_valid_o     = cmd_v_ff;
	assign cmd_o           = cmd_ff;
	assign rd_fwd_valid_o  = fwd_v_ff;
	assign rd_fwd_o        = fwd_ff;

endmodule
`default_nettype wire

// >>> mqe_event_monitor.sv
// Port-level assertions for the queue event monitor
`timescale 1ns/100ps
`default_nettype none
module mqe_event_chk
	import mqe_pkg::*;
(
	input  wire logic                          mclk_i,
	input  wire logic                          rst_n_i,
	input  wire logic                          wr_req_valid_i,
	input  wire logic                          mem_ready_i,
	input  wire logic                          write_major_mode_i,
	input  wire logic                          buffered_write_push_i,
	input  wire logic [INC_W-1:0]              buffered_write_occupancy_i,
	input  wire logic                          mode_request_denied_i,
	input  wire logic [NUM_CTR-1:0][CTL_W-1:0] ctr_ctl_i,
	input  wire logic                          wr_queue_full_o,
	input  wire logic                          wr_posted_o,
	input  wire logic                          cmd_valid_o,
	input  wire logic                          rd_fwd_valid_o,
	input  wire mqe_wr_req_t                   rd_fwd_o,
	input  wire logic [NUM_CTR-1:0][INC_W-1:0] ctr_inc_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	// Writes are taken only while the full flag is low
	wire logic take = wr_req_valid_i && !wr_queue_full_o;

	posted_take_a: assert property (take |=> wr_posted_o)
		else $error("write taken but not posted");
	posted_only_a: assert property (wr_posted_o |-> $past(take))
		else $error("posted without an accepted write");
	mem_gate_a: assert property (cmd_valid_o |-> $past(mem_ready_i))
		else $error("command issued while memory not ready");
	occ_sum_a: assert property (
		(ctr_ctl_i[0][7:0] == EV_BUFFERED_WRITE_OCCUPANCY) [*3]
		|-> ctr_inc_o[0] == $past(buffered_write_occupancy_i, 2))
		else $error("occupancy increment wrong");
	mode_denied_a: assert property (
		(ctr_ctl_i[3][7:0] == EV_MODE_REQUEST_DENIED) [*3]
		|-> ctr_inc_o[3] == $past(mode_request_denied_i, 2))
		else $error("denied mode increment wrong");
	push_read_a: assert property (
		(ctr_ctl_i[1] == {8'h02, EV_BUFFERED_WRITE_PUSH}) [*3]
		|-> ctr_inc_o[1] ==
		$past(buffered_write_push_i && !write_major_mode_i, 2))
		else $error("read mode push increment wrong");
	one_per_a: assert property (
		(ctr_ctl_i[3][7:0] != EV_BUFFERED_WRITE_OCCUPANCY) [*2]
		|-> ctr_inc_o[3] <= 6'h01)
		else $error("more than one per cycle");
	fwd_bytes_a: assert property (rd_fwd_valid_o |-> rd_fwd_o.be != BE_NONE)
		else $error("forward without queued bytes");
	fwd_c: cover property (rd_fwd_valid_o);
	refuse_c: cover property (wr_req_valid_i && wr_queue_full_o);
	occ_c: cover property (ctr_inc_o[0] == OCC_MAX);
endmodule
bind mqe_monitor mqe_event_chk u_chk (
	.mclk_i(mclk_i), .rst_n_i(rst_n_i), .wr_req_valid_i(wr_req_valid_i),
	.mem_ready_i(mem_ready_i), .write_major_mode_i(write_major_mode_i),
	.buffered_write_push_i(buffered_write_push_i),
	.buffered_write_occupancy_i(buffered_write_occupancy_i),
	.mode_request_denied_i(mode_request_denied_i), .ctr_ctl_i(ctr_ctl_i),
	.wr_queue_full_o(wr_queue_full_o), .wr_posted_o(wr_posted_o),
	.cmd_valid_o(cmd_valid_o), .rd_fwd_valid_o(rd_fwd_valid_o),
	.rd_fwd_o(rd_fwd_o), .ctr_inc_o(ctr_inc_o));
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the queue event monitor
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import mqe_pkg::*;
;
	logic                          mclk_i, rst_n_i, rd_v, wr_v, mem_rdy;
	logic                          write_major_mode, push, denied;
	logic [INC_W-1:0]              occ;
	logic [2:0]                    cause;
	logic [NUM_CTR-1:0][CTL_W-1:0] ctl;
	mqe_rd_req_t                   rd_req;
	mqe_wr_req_t                   wr_req, fwd;
	logic                          rq_full, wq_full, posted, cmd_v, fwd_v;
	mqe_cmd_t                      cmd;
	mqe_cmd_t                      cmdq[$];
	logic [NUM_CTR-1:0][INC_W-1:0] inc;
	logic [31:0]                   acc[NUM_CTR], base[NUM_CTR];
	logic [DATA_W-1:0]             fwdd;
	int                            mismatches, tests_run, nfwd, nf0;

	mqe_monitor dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.rd_req_valid_i(rd_v), .rd_req_i(rd_req), .wr_req_valid_i(wr_v),
		.wr_req_i(wr_req), .mem_ready_i(mem_rdy), .write_major_mode_i(write_major_mode),
		.buffered_write_push_i(push), .buffered_write_occupancy_i(occ),
		.mode_switch_cause_i(cause), .mode_request_denied_i(denied),
		.ctr_ctl_i(ctl), .rd_queue_full_o(rq_full), .wr_queue_full_o(wq_full),
		.wr_posted_o(posted), .cmd_valid_o(cmd_v), .cmd_o(cmd),
		.rd_fwd_valid_o(fwd_v), .rd_fwd_o(fwd), .ctr_inc_o(inc));

	initial begin
		mclk_i = 1'b0;
		forever #4 mclk_i = ~mclk_i;
	end

	// Running sums stand in for the counters, so timing slips do not matter
	always @(posedge mclk_i) begin
		for (int c = 0; c < NUM_CTR; c++)
			acc[c] <= acc[c] + 32'(inc[c]);
		if (cmd_v === 1'b1)
			cmdq.push_back(cmd);
		if (fwd_v === 1'b1) begin
			nfwd <= nfwd + 1;
			fwdd <= fwd.data;
		end
	end

	task automatic complete_run;
		$display("Checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask

	task automatic chk(input string what, input logic [63:0] exp,
		input logic [63:0] got);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic chk_inc(input int c, input int exp);
		chk($sformatf("counter %0d sum", c), 64'(exp), 64'(acc[c] - base[c]));
	endtask

	// Stale increments of the old codes drain before the sums are marked
	task automatic set_ctl(input logic [CTL_W-1:0] a, b, c, d);
		ctl = {d, c, b, a};
		tick(5);
		base = acc;
	endtask

	task automatic wait_cmds(input int n);
		for (int i = 0; i < 60 && cmdq.size() < n; i++)
			tick(1);
		if (cmdq.size() < n) begin
			mismatches++;
			$display("CHECK FAILED commands expected %0d seen %0d", n,
				cmdq.size());
			complete_run();
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [63:0] d,
		input logic [7:0] be, input logic exp_post);
		wr_req = '{addr: a, data: d, be: be};
		wr_v = 1'b1;
		tick(1);
		wr_v = 1'b0;
		chk("write posted", 64'(exp_post), 64'(posted));
		tick(1);
	endtask

	task automatic rd(input logic [31:0] a, input logic tc);
		chk("read queue full", 64'h0, 64'(rq_full));
		rd_req = '{time_critical_class: tc, addr: a};
		rd_v = 1'b1;
		tick(1);
		rd_v = 1'b0;
		tick(1);
	endtask

	task automatic mode_events;
		set_ctl({8'h01, EV_BUFFERED_WRITE_PUSH}, {8'h02, EV_BUFFERED_WRITE_PUSH},
			{8'h07, EV_WRITE_TO_READ_MODE_SWITCH},
			{8'hff, EV_MODE_REQUEST_DENIED});
		for (int i = 0; i < 5; i++) begin
			write_major_mode = (i < 3);
			push = 1'b1;
			denied = (i != 4);
			cause = (i == 0) ? 3'h5 : (i == 1) ? 3'h2 : 3'h0;
			tick(1);
		end
		push = 1'b0;
		denied = 1'b0;
		tick(4);
		chk_inc(0, 3);
		chk_inc(1, 2);
		chk_inc(2, 2);
		chk_inc(3, 4);
	endtask

	task automatic occupancy;
		set_ctl({8'h00, EV_BUFFERED_WRITE_OCCUPANCY},
			{8'hff, EV_BUFFERED_WRITE_OCCUPANCY}, 16'h0000, 16'h0025);
		occ = OCC_MAX;
		tick(3);
		occ = 6'h05;
		tick(1);
		occ = 6'h00;
		tick(4);
		chk_inc(0, 101);
		chk_inc(1, 101);
		chk_inc(2, 0);
		chk_inc(3, 0);
	endtask

	task automatic write_match;
		cmdq.delete();
		nf0 = nfwd;
		set_ctl({8'h00, EV_WRITE_QUEUE_ALLOCATIONS},
			{8'h00, EV_READ_QUEUE_ALLOCATIONS},
			{8'h00, EV_WRITE_QUEUE_WRITE_MATCH},
			{8'h00, EV_WRITE_QUEUE_READ_MATCH});
		wr(32'h100, '1, 8'hff, 1'b1);
		wr(32'h100, 64'h0, 8'h0f, 1'b1);
		wr(32'h140, 64'h11, 8'hff, 1'b1);
		wr(32'h180, 64'h22, 8'hff, 1'b1);
		rd(32'h100, 1'b0);
		tick(6);
		chk("forwards", 64'h1, 64'(nfwd - nf0));
		chk("forward data", 64'hffffffff_00000000, fwdd);
		chk_inc(0, 3);
		chk_inc(1, 1);
		chk_inc(2, 1);
		chk_inc(3, 1);
		chk("early commands", 64'h0, 64'(cmdq.size()));
		mem_rdy = 1'b1;
		wait_cmds(3);
		tick(4);
		chk("merged addr", 64'h100, 64'(cmdq[0].addr));
		chk("merged data", 64'hffffffff_00000000, cmdq[0].data);
		chk("total commands", 64'h3, 64'(cmdq.size()));
	endtask

	task automatic fill_write_queue;
		cmdq.delete();
		mem_rdy = 1'b0;
		set_ctl({8'h00, EV_WRITE_QUEUE_FULL_CYCLES},
			{8'h00, EV_WRITE_QUEUE_NONEMPTY_CYCLES},
			{8'h00, EV_WRITE_QUEUE_ALLOCATIONS}, 16'h0000);
		for (int i = 0; i < 8; i++)
			wr(32'h200 + 32'(i) * 32'h40, 64'(i), 8'hff, 1'b1);
		for (int i = 0; i < 10 && wq_full !== 1'b1; i++)
			tick(1);
		chk("write queue full", 64'h1, 64'(wq_full));
		tick(4);
		base = acc;
		wr(32'h400, 64'h0, 8'hff, 1'b0);
		tick(8);
		chk_inc(0, 10);
		chk_inc(1, 10);
		chk_inc(2, 0);
		mem_rdy = 1'b1;
		wait_cmds(8);
		tick(4);
		chk("drained commands", 64'h8, 64'(cmdq.size()));
		base = acc;
		tick(6);
		chk_inc(1, 0);
	endtask

	task automatic read_path;
		cmdq.delete();
		mem_rdy = 1'b0;
		set_ctl({8'h00, EV_READ_QUEUE_NONEMPTY_CYCLES},
			{8'h80, EV_READ_COLUMN_RANK_SEVEN}, {8'h00, EV_READ_QUEUE_ALLOCATIONS},
			{8'h01, EV_READ_COLUMN_RANK_SEVEN});
		rd(32'h3f, 1'b1);
		rd(32'h38, 1'b0);
		tick(4);
		nf0 = acc[0];
		tick(10);
		chk("read nonempty cycles", 64'h0a, 64'(acc[0] - nf0));
		mem_rdy = 1'b1;
		wait_cmds(2);
		tick(4);
		chk("first read", {1'b0, 32'h3f}, {cmdq[0].is_write, cmdq[0].addr});
		chk("second read", {1'b0, 32'h38}, {cmdq[1].is_write, cmdq[1].addr});
		chk_inc(1, 1);
		chk_inc(2, 2);
		chk_inc(3, 1);
		base = acc;
		tick(5);
		chk_inc(0, 0);
	endtask

	task automatic write_ranks;
		cmdq.delete();
		set_ctl({8'h08, EV_WRITE_COLUMN_RANK_ZERO},
			{8'h20, EV_WRITE_COLUMN_RANK_ONE}, {8'h01, EV_WRITE_COLUMN_RANK_TWO},
			{8'hf7, EV_WRITE_COLUMN_RANK_ZERO});
		wr(32'h03, 64'h1, 8'hff, 1'b1);
		wr(32'h0d, 64'h2, 8'hff, 1'b1);
		wr(32'h10, 64'h3, 8'hff, 1'b1);
		wait_cmds(3);
		tick(4);
		chk_inc(0, 1);
		chk_inc(1, 1);
		chk_inc(2, 1);
		chk_inc(3, 0);
	endtask

	initial begin
		{rst_n_i, rd_v, wr_v, mem_rdy, write_major_mode, push, denied} = '0;
		{occ, cause, ctl, rd_req, wr_req} = '0;
		{mismatches, tests_run, nfwd} = '0;
		for (int c = 0; c < NUM_CTR; c++)
			acc[c] = 32'h0;
		tick(3);
		chk("reset outputs", 64'h0, 64'({rq_full, wq_full, posted, cmd_v,
			fwd_v, inc}));
		rst_n_i = 1'b1;
		tick(1);
		mode_events();
		occupancy();
		write_match();
		fill_write_queue();
		read_path();
		write_ranks();
		complete_run();
	end
endmodule
`default_nettype wire
